/* File: src/ppf_regs.svh */
// register offsets, reset values and timing figures of the phy packet framer
`ifndef PPF_REGS_SVH
`define PPF_REGS_SVH
`define PPF_OFF_NODE_ID 8'h00
`define PPF_OFF_INT_STAT 8'h04
`define PPF_OFF_INT_MASK 8'h08
`define PPF_OFF_PHY_STATE 8'h0c
`define PPF_OFF_TXQ0 8'h70
`define PPF_OFF_TXQ1 8'h78
`define PPF_NODE_ID_RST 16'hffff
`define PPF_MASK_RST 6'h00
`define PPF_GAP_DEFAULT 6'h3f
`define PPF_MARKER 16'h00e0
`define PPF_MARKER_CLR 16'h0000
`define PPF_ID_CONFIG 2'h0
`define PPF_ID_LINK_ON 2'h1
`define PPF_ID_SELF_ID 2'h2
`define PPF_EXT_PING 4'h0
`define PPF_RESPONSE_TIME_NS 1000
`define PPF_CLK_NS 10
// status bit positions
`define PPF_EV_TX_DONE 0
`define PPF_EV_CONFIG 1
`define PPF_EV_LINK_ON 2
`define PPF_EV_PING 3
`define PPF_EV_HDR_ERR 4
`define PPF_EV_CHK_ERR 5
`define PPF_EV_W 6
// phy state field positions
`define PPF_PS_ROOT 8
`define PPF_PS_BUSY 16
`endif

/* File: src/ppf_pkg.sv */
// types of the phy packet framer
`default_nettype none
package ppf_pkg;
	typedef enum logic [1:0] {PPF_TX_IDLE, PPF_TX_Q0, PPF_TX_Q1} ppf_tx_e;
	typedef enum logic {PPF_RX_Q0, PPF_RX_Q1} ppf_rx_e;
	typedef struct packed {
		ppf_tx_e tx_st;
		ppf_rx_e rx_st;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic [31:0] tx_q1;
		logic [31:0] tx_data;
		logic tx_phy;
		logic [31:0] rx_q0;
		logic [15:0] node_id;
		logic [5:0] int_stat;
		logic [5:0] int_mask;
		logic [5:0] gap;
		logic force_root;
		logic [1:0] since;
		logic link_on;
		logic selfid_req;
		logic [15:0] selfid_info;
	} ppf_state_s;
endpackage : ppf_pkg
`default_nettype wire

/* File: src/ppf_framer.sv */
// phy packet framer: ahb-lite registers, phy packet transmit and receive
//
// How it works
// - 00E0h in first quadlet marks phy packet
// - marker replaced by 0000h toward phy
// - leading 16 bits equal node id: header error
// - identifier 00 config, 01 link-on, 10 self-id
// - force-root set if root select matches, else cleared
// - force-root clear: root select ignored
// - gap update flag loads arbitration gap count
// - new gap count survives first bus reset
// - gap count reverts after second bus reset
// - config with both flags clear ignored, except a ping to this node
// - link-on to this node raises link-on event
// - ping to this node requests self-id
// - self-id request within response time
// - self-id content reflects present state
`timescale 1ns/100ps
`default_nettype none
`include "ppf_regs.svh"
module ppf_framer #(
	parameter int RESPONSE_TIME_NS = `PPF_RESPONSE_TIME_NS
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	output logic TX_VALID,
	output logic [31:0] TX_DATA,
	output logic TX_PHY,
	input wire logic TX_READY,
	input wire logic RX_VALID,
	input wire logic [31:0] RX_DATA,
	input wire logic BUS_RESET,
	output logic LINK_ON,
	output logic SELFID_REQ,
	output logic [15:0] SELFID_INFO,
	output logic [5:0] GAP_COUNT,
	output logic FORCE_ROOT,
	output logic IRQ
);
	localparam int RESP_CYC = RESPONSE_TIME_NS / `PPF_CLK_NS;

	// refuse a response time shorter than the framer's own latency
	generate
		if (RESP_CYC < 2) begin : g_chk
			$error("response time below two clock cycles");
		end
	endgenerate

	// -----------------------------------------------------------------
	// decode helpers
	// -----------------------------------------------------------------
	function automatic logic is_port(input logic [7:0] a);
		is_port = (a == `PPF_OFF_TXQ0) || (a == `PPF_OFF_TXQ1);
	endfunction : is_port

	ppf_pkg::ppf_state_s r_reg;
	ppf_pkg::ppf_state_s r_next;

	logic addr_ok;
	logic stall;
	logic wr_do;
	logic [5:0] evt;
	logic [5:0] clr;
	logic [31:0] q0;
	logic [5:0] phys;
	logic [31:0] q_first;

	// address phase taken, write data phase to a transmit port stalled while sending
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign stall = r_reg.wr_pend && is_port(r_reg.wr_addr) &&
		(r_reg.tx_st != ppf_pkg::PPF_TX_IDLE);
	assign wr_do = r_reg.wr_pend && !stall;
	assign phys = r_reg.node_id[5:0];
	assign q0 = r_reg.rx_q0;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		evt = '0;
		clr = '0;
		q_first = HWDATA;
		r_next.link_on = 1'b0;
		r_next.selfid_req = 1'b0;

		// bus write in its data phase
		if (wr_do) begin
			r_next.wr_pend = 1'b0;
			case (r_reg.wr_addr)
				`PPF_OFF_NODE_ID: begin
					r_next.node_id = HWDATA[15:0];
				end
				`PPF_OFF_INT_STAT: begin
					clr = HWDATA[5:0];
				end
				`PPF_OFF_INT_MASK: begin
					r_next.int_mask = HWDATA[5:0];
				end
				`PPF_OFF_TXQ0: begin
					// marker identifies a phy packet
					r_next.tx_phy = (HWDATA[15:0] == `PPF_MARKER);
					if (HWDATA[15:0] == `PPF_MARKER) begin
						q_first[15:0] = `PPF_MARKER_CLR;
					end
					r_next.tx_data = q_first;
				end
				`PPF_OFF_TXQ1: begin
					r_next.tx_q1 = HWDATA;
					r_next.tx_st = ppf_pkg::PPF_TX_Q0;
				end
				default: begin
				end
			endcase
		end

		// new address phase
		if (addr_ok) begin
			r_next.wr_pend = HWRITE;
			r_next.wr_addr = HADDR[7:0];
			case (HADDR[7:0])
				`PPF_OFF_NODE_ID: r_next.rdata = {16'h0000, r_reg.node_id};
				`PPF_OFF_INT_STAT: r_next.rdata = {26'h0, r_reg.int_stat};
				`PPF_OFF_INT_MASK: r_next.rdata = {26'h0, r_reg.int_mask};
				`PPF_OFF_PHY_STATE: begin
					r_next.rdata = {15'h0,
						r_reg.tx_st != ppf_pkg::PPF_TX_IDLE,
						7'h00, r_reg.force_root, 2'h0, r_reg.gap};
				end
				default: r_next.rdata = 32'h0000_0000;
			endcase
		end

		// quadlets toward the phy interface
		case (r_reg.tx_st)
			ppf_pkg::PPF_TX_Q0: begin
				if (TX_READY) begin
					r_next.tx_data = r_reg.tx_q1;
					r_next.tx_st = ppf_pkg::PPF_TX_Q1;
				end
			end
			ppf_pkg::PPF_TX_Q1: begin
				if (TX_READY) begin
					r_next.tx_st = ppf_pkg::PPF_TX_IDLE;
					evt[`PPF_EV_TX_DONE] = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// bus reset ages a freshly loaded gap count
		if (BUS_RESET) begin
			if (r_reg.since == 2'h0) begin
				r_next.since = 2'h1;
			end else if (r_reg.since == 2'h1) begin
				r_next.gap = `PPF_GAP_DEFAULT;
				r_next.since = 2'h2;
			end
		end

		// received phy packets, quadlet pairs
		if (RX_VALID) begin
			case (r_reg.rx_st)
				ppf_pkg::PPF_RX_Q0: begin
					r_next.rx_q0 = RX_DATA;
					r_next.rx_st = ppf_pkg::PPF_RX_Q1;
					// looks like data addressed to this node
					if (RX_DATA[31:16] == r_reg.node_id) begin
						evt[`PPF_EV_HDR_ERR] = 1'b1;
					end
				end
				ppf_pkg::PPF_RX_Q1: begin
					r_next.rx_st = ppf_pkg::PPF_RX_Q0;
					if (RX_DATA != ~q0) begin
						evt[`PPF_EV_CHK_ERR] = 1'b1;
					end else begin
						case (q0[31:30])
							`PPF_ID_CONFIG: begin
								if (q0[23]) begin
									r_next.force_root = (q0[29:24] == phys);
								end
								if (q0[22]) begin
									r_next.gap = q0[21:16];
									r_next.since = 2'h0;
								end
								if (q0[23] || q0[22]) begin
									evt[`PPF_EV_CONFIG] = 1'b1;
								end else if (q0[21:18] == `PPF_EXT_PING &&
									q0[29:24] == phys) begin
									// ping answered next cycle
									r_next.selfid_req = 1'b1;
									evt[`PPF_EV_PING] = 1'b1;
								end
								// other reserved forms fall through
							end
							`PPF_ID_LINK_ON: begin
								if (q0[29:24] == phys) begin
									r_next.link_on = 1'b1;
									evt[`PPF_EV_LINK_ON] = 1'b1;
								end
							end
							default: begin
							end
						endcase
					end
				end
				default: begin
					r_next.rx_st = ppf_pkg::PPF_RX_Q0;
				end
			endcase
		end

		// self-id content taken from updated state
		r_next.selfid_info = {phys, r_next.force_root, r_next.gap, 3'h0};

		// sticky status, a set beats a same-cycle clear
		r_next.int_stat = (r_reg.int_stat & ~clr) | evt;
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			r_reg <= '0;
			r_reg.tx_st <= ppf_pkg::PPF_TX_IDLE;
			r_reg.rx_st <= ppf_pkg::PPF_RX_Q0;
			r_reg.node_id <= `PPF_NODE_ID_RST;
			r_reg.int_mask <= `PPF_MASK_RST;
			r_reg.gap <= `PPF_GAP_DEFAULT;
			r_reg.since <= 2'h2;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs
	assign HREADYOUT = !stall;
	assign HRDATA = r_reg.rdata;
	assign HRESP = 1'b0;
	assign TX_VALID = (r_reg.tx_st != ppf_pkg::PPF_TX_IDLE);
	assign TX_DATA = r_reg.tx_data;
	assign TX_PHY = r_reg.tx_phy;
	assign LINK_ON = r_reg.link_on;
	assign SELFID_REQ = r_reg.selfid_req;
	assign SELFID_INFO = r_reg.selfid_info;
	assign GAP_COUNT = r_reg.gap;
	assign FORCE_ROOT = r_reg.force_root;
	assign IRQ = |(r_reg.int_stat & r_reg.int_mask);

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	logic rx_pair;
	assign rx_pair = RX_VALID && (r_reg.rx_st == ppf_pkg::PPF_RX_Q1) &&
		(RX_DATA == ~q0);

	marker_cleared_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		wr_do && r_reg.wr_addr == `PPF_OFF_TXQ0 &&
		HWDATA[15:0] == `PPF_MARKER |=>
		TX_DATA[15:0] == `PPF_MARKER_CLR && TX_PHY)
		else $error("marker not cleared");

	header_error_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		RX_VALID && r_reg.rx_st == ppf_pkg::PPF_RX_Q0 &&
		RX_DATA[31:16] == r_reg.node_id |=> r_reg.int_stat[`PPF_EV_HDR_ERR])
		else $error("header error missed");

	root_select_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && q0[31:30] == `PPF_ID_CONFIG && q0[23] |=>
		FORCE_ROOT == ($past(q0[29:24]) == phys))
		else $error("force root wrong");

	root_ignored_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && !q0[23] |=> $stable(FORCE_ROOT))
		else $error("root select not ignored");

	gap_load_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && q0[31:30] == `PPF_ID_CONFIG && q0[22] |=>
		GAP_COUNT == $past(q0[21:16]))
		else $error("gap count not loaded");

	gap_revert_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		BUS_RESET && r_reg.since == 2'h1 && !rx_pair |=>
		GAP_COUNT == `PPF_GAP_DEFAULT)
		else $error("gap count not reverted");

	gap_hold_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		BUS_RESET && r_reg.since == 2'h0 && !rx_pair |=> $stable(GAP_COUNT))
		else $error("gap count lost at first reset");

	link_on_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && q0[31:30] == `PPF_ID_LINK_ON && q0[29:24] == phys |=>
		LINK_ON ##1 !LINK_ON)
		else $error("link-on event missing");

	ping_reply_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && q0[31:30] == `PPF_ID_CONFIG && !q0[23] && !q0[22] &&
		q0[21:18] == `PPF_EXT_PING && q0[29:24] == phys |->
		##[1:2] SELFID_REQ && SELFID_INFO[15:10] == phys)
		else $error("self-id request late");

	reserved_cfg_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		rx_pair && q0[31:30] == `PPF_ID_CONFIG && !q0[23] && !q0[22] |=>
		$stable(FORCE_ROOT) && ($stable(GAP_COUNT) || $past(BUS_RESET)))
		else $error("reserved config acted on");

	inverse_check_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		RX_VALID && r_reg.rx_st == ppf_pkg::PPF_RX_Q1 && RX_DATA != ~q0 |=>
		r_reg.int_stat[`PPF_EV_CHK_ERR] && !LINK_ON && !SELFID_REQ)
		else $error("inverse check failed");

	tx_order_a: assert property (
		@(posedge REF_CLK) disable iff (RST)
		TX_VALID && TX_READY && r_reg.tx_st == ppf_pkg::PPF_TX_Q0 |=>
		TX_VALID && TX_DATA == $past(r_reg.tx_q1))
		else $error("second quadlet not sent");

endmodule : ppf_framer
`default_nettype wire

/* File: tb/ppf_phy_model.sv */
// phy side partner: takes transmit quadlets, sends received packets
`timescale 1ns/100ps
`default_nettype none
module ppf_phy_model (
	input wire logic clk,
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_phy,
	output logic tx_ready,
	output logic rx_valid,
	output logic [31:0] rx_data
);
	logic [31:0] tx_q [2];
	logic tx_phy_seen;
	int tx_n = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 32'h0;
	end
	// accept every other cycle so the framer always sees a stall
	always @(posedge clk) begin
		tx_ready <= tx_valid & ~tx_ready;
		if (tx_valid && tx_ready) begin
			if (tx_n < 2) tx_q[tx_n] = tx_data;
			if (tx_n == 0) tx_phy_seen = tx_phy;
			tx_n = tx_n + 1;
		end
	end
	// one packet of two quadlets; bad breaks the inverse on purpose
	task automatic send(logic [31:0] q0, logic bad);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= q0;
		@(posedge clk);
		rx_data <= bad ? q0 ^ 32'h1 : ~q0;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= q0; // idle line shows first quadlet again
	endtask : send
endmodule : ppf_phy_model
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench of the phy packet framer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic bus_reset = 1'b0;
	logic hready, tx_valid, tx_phy, tx_ready, rx_valid, link_on;
	logic selfid_req, force_root, irq, hresp;
	logic [31:0] hrdata, tx_data, rx_data, rd;
	logic [15:0] selfid_info;
	logic [5:0] gap_count;
	int failures = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	ppf_framer ppf_framer_i (.REF_CLK(clk), .RST(rst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
		.HRDATA(hrdata), .HRESP(hresp), .TX_VALID(tx_valid),
		.TX_DATA(tx_data),
		.TX_PHY(tx_phy), .TX_READY(tx_ready), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .BUS_RESET(bus_reset), .LINK_ON(link_on),
		.SELFID_REQ(selfid_req), .SELFID_INFO(selfid_info),
		.GAP_COUNT(gap_count), .FORCE_ROOT(force_root), .IRQ(irq));
	ppf_phy_model ppf_phy_model_i (.clk(clk), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_phy(tx_phy), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one single ahb-lite transfer; read data lands in rd
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		#1;
	endtask : bus
	function automatic logic [31:0] pq(logic [1:0] id, logic [5:0] ph,
		logic r, logic t, logic [5:0] g);
		return {id, ph, r, t, g, 16'h00e0};
	endfunction : pq
	task automatic pkt(logic [31:0] q, logic bad);
		ppf_phy_model_i.send(q, bad);
		#1;
	endtask : pkt
	task automatic brst;
		@(posedge clk);
		bus_reset <= 1'b1;
		@(posedge clk);
		bus_reset <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : brst
	task automatic t_tx(logic [31:0] q, logic [31:0] e, logic ph);
		ppf_phy_model_i.tx_n = 0;
		bus(1'b1, 8'h04, 32'h3f);
		bus(1'b1, 8'h70, q);
		bus(1'b1, 8'h78, ~q);
		for (int i = 0; i < 50 && ppf_phy_model_i.tx_n < 2; i++) begin
			@(posedge clk);
		end
		#1;
		chk("tx_q0", e, ppf_phy_model_i.tx_q[0]);
		chk("tx_q1", ~q, ppf_phy_model_i.tx_q[1]);
		chk("tx_phy", ph, ppf_phy_model_i.tx_phy_seen);
		chk("tx_count", 2, ppf_phy_model_i.tx_n);
		bus(1'b0, 8'h04, 32'h0);
		chk("tx_done", 1, rd[0]);
		$display("t_tx done");
	endtask : t_tx
	// write to the transmit port while busy must wait for idle
	task automatic t_stall;
		ppf_phy_model_i.tx_n = 0;
		bus(1'b1, 8'h70, 32'h0000_00e0);
		bus(1'b1, 8'h78, 32'hffff_ff1f);
		bus(1'b1, 8'h70, 32'h5555_0000);
		chk("stall_n", 2, ppf_phy_model_i.tx_n);
		chk("stall_q0", 0, ppf_phy_model_i.tx_q[0]);
		chk("stall_q1", 32'hffff_ff1f, ppf_phy_model_i.tx_q[1]);
		$display("t_stall done");
	endtask : t_stall
	// reset values and plain register access
	task automatic t_regs;
		chk("gap_rst", 6'h3f, gap_count);
		chk("hresp", 0, hresp);
		bus(1'b0, 8'h00, 32'h0);
		chk("node_rst", 16'hffff, rd);
		bus(1'b1, 8'h00, 32'h5);
		bus(1'b0, 8'h00, 32'h0);
		chk("node_id", 32'h5, rd);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", 0, rd);
		chk("hresp_rd", 0, hresp);
		$display("t_regs done");
	endtask : t_regs
	// reset in mid-run brings every register back
	task automatic t_rst;
		bus(1'b1, 8'h08, 32'h3f);
		chk("pre_irq", 1, irq);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst_irq", 0, irq);
		chk("rst_gap", 6'h3f, gap_count);
		chk("rst_root", 0, force_root);
		bus(1'b0, 8'h00, 32'h0);
		chk("rst_node", 16'hffff, rd);
		$display("t_rst done");
	endtask : t_rst
	task automatic t_cfg;
		pkt(pq(2'h0, 6'h05, 1'b1, 1'b1, 6'h10), 1'b0);
		chk("root_sel", 1, force_root);
		chk("gap_new", 6'h10, gap_count);
		bus(1'b0, 8'h0c, 32'h0);
		chk("phy_state", 32'h110, rd);
		pkt(pq(2'h0, 6'h07, 1'b0, 1'b1, 6'h20), 1'b0);
		chk("root_keep", 1, force_root);
		chk("gap_upd", 6'h20, gap_count);
		pkt(pq(2'h0, 6'h07, 1'b1, 1'b0, 6'h01), 1'b0);
		chk("root_other", 0, force_root);
		chk("gap_keep", 6'h20, gap_count);
		pkt(pq(2'h0, 6'h05, 1'b0, 1'b0, 6'h0c), 1'b0);
		chk("rsvd_gap", 6'h20, gap_count);
		chk("rsvd_req", 0, selfid_req);
		brst;
		chk("gap_rst1", 6'h20, gap_count);
		brst;
		chk("gap_rst2", 6'h3f, gap_count);
		$display("t_cfg done");
	endtask : t_cfg
	task automatic t_ping;
		bus(1'b1, 8'h04, 32'h3f);
		pkt(pq(2'h0, 6'h05, 1'b1, 1'b1, 6'h2a), 1'b0);
		pkt(pq(2'h0, 6'h05, 1'b0, 1'b0, 6'h00), 1'b0);
		chk("ping_req", 1, selfid_req);
		chk("ping_info", {6'h05, 1'b1, 6'h2a, 3'h0}, selfid_info);
		@(posedge clk);
		#1;
		chk("req_pulse", 0, selfid_req);
		bus(1'b0, 8'h04, 32'h0);
		chk("stat_ping", 32'ha, rd);
		pkt(pq(2'h0, 6'h07, 1'b0, 1'b0, 6'h00), 1'b0);
		chk("ping_other", 0, selfid_req);
		$display("t_ping done");
	endtask : t_ping
	task automatic t_link;
		bus(1'b1, 8'h04, 32'h3f);
		bus(1'b1, 8'h08, 32'h4);
		bus(1'b0, 8'h08, 32'h0);
		chk("mask_rd", 32'h4, rd);
		pkt(pq(2'h1, 6'h05, 1'b0, 1'b0, 6'h00), 1'b0);
		chk("link_on", 1, link_on);
		chk("irq_on", 1, irq);
		bus(1'b0, 8'h04, 32'h0);
		chk("stat_link", 32'h4, rd);
		bus(1'b1, 8'h08, 32'h0);
		chk("irq_mask", 0, irq);
		bus(1'b1, 8'h08, 32'h4);
		bus(1'b1, 8'h04, 32'h4);
		chk("irq_clr", 0, irq);
		$display("t_link done");
	endtask : t_link
	task automatic t_err;
		bus(1'b1, 8'h04, 32'h3f);
		pkt(pq(2'h0, 6'h00, 1'b0, 1'b0, 6'h05), 1'b0);
		bus(1'b0, 8'h04, 32'h0);
		chk("hdr_err", 32'h10, rd);
		bus(1'b1, 8'h04, 32'h3f);
		pkt(pq(2'h0, 6'h05, 1'b0, 1'b1, 6'h11), 1'b1);
		chk("inv_gap", 6'h2a, gap_count);
		bus(1'b0, 8'h04, 32'h0);
		chk("inv_err", 32'h20, rd);
		$display("t_err done");
	endtask : t_err
	task automatic complete_run;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_regs;
		t_tx({16'h1234, 16'h00e0}, 32'h12340000, 1'b1);
		t_tx(32'h12345678, 32'h12345678, 1'b0);
		t_stall;
		t_cfg;
		t_ping;
		t_link;
		t_err;
		t_rst;
		complete_run;
	end
	// watchdog against a hang
	initial begin
		#100000;
		failures++;
		complete_run;
	end
endmodule : tb_top
`default_nettype wire
